//--- rsw_regs.svh
// Register offsets, fields, reset values and timing counts of the reset
// sequencer. Assumes a 100 MHz clock and a 10 ns period.
`ifndef RSW_REGS_SVH
`define RSW_REGS_SVH

// =====================================================================
// Register offsets
// =====================================================================
`define RSW_ADDR_WDSEL 4'h0
`define RSW_ADDR_KICK 4'h1
`define RSW_ADDR_STAT 4'h2
`define RSW_ADDR_CTRL 4'h3

// =====================================================================
// Fields and reset values
// =====================================================================
`define RSW_WDSEL_OFF 2'h0
`define RSW_WDSEL_64K 2'h1
`define RSW_WDSEL_128K 2'h3
`define RSW_WDSEL_RST 2'h3
`define RSW_KICK_BIT 0
`define RSW_STAT_WDCY_BIT 0
`define RSW_STAT_STOP_BIT 1
`define RSW_STAT_RUN_BIT 2
`define RSW_STAT_HIGHTH_BIT 3
`define RSW_CTRL_STOP_BIT 0
`define RSW_CTRL_HALT_BIT 1

// =====================================================================
// Timing
// =====================================================================
`define RSW_CLK_NS 10
`define RSW_CARRY_PERIOD_MS 100
`define RSW_CARRY_HALF_MS 50
`define RSW_WD_64K 32'h0001_0000
`define RSW_WD_128K 32'h0002_0000

`endif

//--- rsw_pkg.sv
// Types shared by the reset sequencer.
// Assumes the constants of rsw_regs.svh.
package rsw_pkg;

   // ==================================================================
   // Sequencer states
   // ==================================================================
   typedef enum logic [2:0] {
      RSW_ST_RESET = 3'b000,
      RSW_ST_WAIT = 3'b001,
      RSW_ST_RUN = 3'b010,
      RSW_ST_STOP = 3'b011,
      RSW_ST_WAKE = 3'b100
   } rsw_state_t;

endpackage : rsw_pkg

//--- rsw_reset_seq.sv
// Reset sequencer and watchdog for a small controller core.
// Assumes asynchronous pins, a supply detector flag and a clock-enable.
`include "rsw_regs.svh"

module rsw_reset_seq #(
   parameter int CARRY_HALF_CYC =
      `RSW_CARRY_HALF_MS * 1000000 / `RSW_CLK_NS,
   parameter int WD_LONG = `RSW_WD_128K,
   parameter int WD_SHORT = `RSW_WD_64K
) (
   // Clock, reset and enable.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Pins and detector.
   input wire logic supply_low_clear_i,
   input wire logic reset_n_i,
   input wire logic chip_enable_i,
   input wire logic ext_int_i,
   input wire logic wake_port_i,
   // Instruction strobe from the core.
   input wire logic instr_i,
   // Register port.
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Sequencer outputs.
   output logic osc_en_o,
   output logic core_rst_o,
   output logic core_run_o,
   output logic high_thresh_o
);

   // =================================================================
   // Pin synchronisers
   // =================================================================
   logic [4:0] s1_q;
   logic [4:0] s2_q;
   logic [4:0] raw;
   assign raw = {wake_port_i, ext_int_i, chip_enable_i, reset_n_i,
                 supply_low_clear_i};
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= 5'h06;
         s2_q <= 5'h06;
      end else if (ce_i) begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end
   wire supply_low_clear = s2_q[0];
   wire pin_rst = !s2_q[1];
   wire chip_en = s2_q[2];
   wire wake = s2_q[3] || s2_q[4];

   // =================================================================
   // State and counters
   // =================================================================
   rsw_pkg::rsw_state_t st_q, st_d;
   logic [31:0] tmr_q;
   logic [31:0] wd_q;
   logic [1:0] wdsel_q;
   logic wdsel_lock_q;
   logic wdcy_q;
   logic ce_prev_q;
   logic ce_pend_q;
   logic stop_req_q;
   logic halt_q;
   logic hth_q;
   logic [7:0] rdata_q;

   wire carry = (tmr_q == 32'(CARRY_HALF_CYC - 1));
   wire hard_rst = supply_low_clear || pin_rst;
   wire ce_rise = chip_en && !ce_prev_q;
   wire running = (st_q == rsw_pkg::RSW_ST_RUN);

   // Watchdog limit decoded from the interval selection.
   function automatic logic [31:0] wd_limit(input logic [1:0] sel);
      case (sel)
         `RSW_WDSEL_64K: wd_limit = 32'(WD_SHORT);
         `RSW_WDSEL_128K: wd_limit = 32'(WD_LONG);
         default: wd_limit = 32'h0;
      endcase
   endfunction : wd_limit

   wire [31:0] lim = wd_limit(wdsel_q);
   wire wd_on = (lim != 32'h0);
   wire wd_count = running && !halt_q && !stop_req_q && instr_i;
   wire wd_exp = wd_on && wd_count && (wd_q == lim - 32'h1);
   wire kick = wr_i && addr_i == `RSW_ADDR_KICK &&
               wdata_i[`RSW_KICK_BIT];
   wire rd_stat = rd_i && addr_i == `RSW_ADDR_STAT;

   always_comb begin
      st_d = st_q;
      case (st_q)
         rsw_pkg::RSW_ST_RESET: st_d = rsw_pkg::RSW_ST_WAIT;
         rsw_pkg::RSW_ST_WAIT: if (carry) st_d = rsw_pkg::RSW_ST_RUN;
         rsw_pkg::RSW_ST_RUN: begin
            if (wd_exp) st_d = rsw_pkg::RSW_ST_RESET;
            else if (stop_req_q) st_d = rsw_pkg::RSW_ST_STOP;
            else if (ce_pend_q && carry) st_d = rsw_pkg::RSW_ST_RESET;
         end
         rsw_pkg::RSW_ST_STOP:
            if (wake) st_d = rsw_pkg::RSW_ST_WAKE;
         rsw_pkg::RSW_ST_WAKE: if (carry) st_d = rsw_pkg::RSW_ST_RUN;
         default: st_d = rsw_pkg::RSW_ST_RESET;
      endcase
      if (hard_rst) st_d = rsw_pkg::RSW_ST_RESET;
   end

   // Threshold follows the next state so it is high when the core starts.
   wire hth_d = (st_d == rsw_pkg::RSW_ST_STOP) ? 1'b0 :
                (st_q == rsw_pkg::RSW_ST_WAKE && !carry) ? hth_q :
                1'b1;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= rsw_pkg::RSW_ST_RESET;
         tmr_q <= 32'h0;
         ce_prev_q <= 1'b0;
         ce_pend_q <= 1'b0;
         hth_q <= 1'b1;
      end else if (ce_i) begin
         st_q <= st_d;
         ce_prev_q <= chip_en;
         // Carry timer held clear while oscillator is stopped.
         if (hard_rst || st_q == rsw_pkg::RSW_ST_STOP || carry)
            tmr_q <= 32'h0;
         else
            tmr_q <= tmr_q + 32'h1;
         // Rises before the run state are absorbed by the start.
         if (hard_rst || st_q != rsw_pkg::RSW_ST_RUN) ce_pend_q <= 1'b0;
         else if (ce_rise) ce_pend_q <= 1'b1;
         else if (carry) ce_pend_q <= 1'b0;
         hth_q <= hth_d;
      end
   end

   // =================================================================
   // Watchdog and registers
   // =================================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wd_q <= 32'h0;
         wdsel_q <= `RSW_WDSEL_RST;
         wdsel_lock_q <= 1'b0;
         wdcy_q <= 1'b0;
         stop_req_q <= 1'b0;
         halt_q <= 1'b0;
         rdata_q <= 8'h00;
      end else if (ce_i) begin
         if (hard_rst || kick || wd_exp) wd_q <= 32'h0;
         else if (wd_count) wd_q <= wd_q + 32'h1;
         if (hard_rst) begin
            wdsel_q <= `RSW_WDSEL_RST;
            wdsel_lock_q <= 1'b0;
         end else if (wr_i && addr_i == `RSW_ADDR_WDSEL &&
                      !wdsel_lock_q) begin
            wdsel_q <= wdata_i[1:0] & 2'h3;
            wdsel_lock_q <= 1'b1;
         end
         if (hard_rst) wdcy_q <= 1'b0;
         else if (wd_exp) wdcy_q <= 1'b1;
         else if (rd_stat) wdcy_q <= 1'b0;
         if (hard_rst || st_q == rsw_pkg::RSW_ST_RESET) begin
            stop_req_q <= 1'b0;
            halt_q <= 1'b0;
         end else if (wr_i && addr_i == `RSW_ADDR_CTRL) begin
            stop_req_q <= wdata_i[`RSW_CTRL_STOP_BIT];
            halt_q <= wdata_i[`RSW_CTRL_HALT_BIT];
         end else if (st_q == rsw_pkg::RSW_ST_STOP) begin
            stop_req_q <= 1'b0;
         end
         rdata_q <= 8'h00;
         if (rd_i) begin
            case (addr_i)
               `RSW_ADDR_WDSEL: rdata_q <= {6'h00, wdsel_q};
               `RSW_ADDR_STAT: rdata_q <= {4'h0, hth_q, running,
                  st_q == rsw_pkg::RSW_ST_STOP, wdcy_q};
               `RSW_ADDR_CTRL: rdata_q <= {6'h00, halt_q, stop_req_q};
               default: rdata_q <= 8'h00;
            endcase
         end
      end
   end

   // =================================================================
   // Outputs
   // =================================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_en_o <= 1'b0;
         core_rst_o <= 1'b1;
         core_run_o <= 1'b0;
         high_thresh_o <= 1'b1;
      end else if (ce_i) begin
         osc_en_o <= !hard_rst && st_d != rsw_pkg::RSW_ST_STOP;
         core_rst_o <= st_d == rsw_pkg::RSW_ST_RESET;
         core_run_o <= st_d == rsw_pkg::RSW_ST_RUN;
         high_thresh_o <= hth_d;
      end
   end
   assign rdata_o = rdata_q;

endmodule : rsw_reset_seq

//--- rsw_reset_seq_monitor.sv
// Checker for the reset sequencer ports.
// Assumes one clock domain and the sync reset rst_i.
module rsw_reset_seq_monitor #(
   parameter int CARRY_HALF_CYC = 20,
   parameter int WD_LONG = 16,
   parameter int WD_SHORT = 8
) (
   // Clock, reset and enable.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Pins and register port.
   input wire logic supply_low_clear_i,
   input wire logic reset_n_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // Sequencer outputs.
   input wire logic osc_en_o,
   input wire logic core_rst_o,
   input wire logic core_run_o,
   input wire logic high_thresh_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // =========================
   // Properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_SUPPLY: assert property (supply_low_clear_i[*4] |->
      !osc_en_o && !core_run_o) else $error("runs in supply low");
   AST_PIN: assert property ((!reset_n_i)[*4] |->
      !osc_en_o && !core_run_o) else $error("runs in pin reset");
   AST_RUN_OSC: assert property (core_run_o |-> osc_en_o)
      else $error("run without oscillator");
   AST_RST_NORUN: assert property (core_rst_o |-> !core_run_o)
      else $error("run during core reset");
   AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data without read");
   AST_CE_HOLD: assert property (!ce_i |=> $stable(core_run_o))
      else $error("state moved with enable low");
   AST_THR_RUN: assert property (core_run_o |-> high_thresh_o)
      else $error("low threshold while running");
   AST_RUN_START: assert property ($rose(core_run_o) |->
      $past(osc_en_o, 2)) else $error("start without oscillator");
   cover property ($rose(core_run_o));
   cover property ($fell(high_thresh_o));
   cover property (rd_i ##1 rdata_o != 8'h00);
endmodule : rsw_reset_seq_monitor

bind rsw_reset_seq rsw_reset_seq_monitor #(
   .CARRY_HALF_CYC(CARRY_HALF_CYC), .WD_LONG(WD_LONG),
   .WD_SHORT(WD_SHORT)) mon_u (.clk_i, .rst_i, .ce_i,
   .supply_low_clear_i, .reset_n_i, .rd_i, .rdata_o, .osc_en_o,
   .core_rst_o, .core_run_o, .high_thresh_o);

//--- rsw_pins_model.sv
// Model of the supply detector and the reset, enable and wake pins.
// Assumes the caller enters pulse just after a rising clock edge.
module rsw_pins_model (
   // Clock.
   input wire logic clk_i,
   // Pins.
   output logic supply_low_clear_o,
   output logic reset_n_o,
   output logic chip_enable_o,
   output logic ext_int_o,
   output logic wake_port_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // =========================
   // Pin drivers
   logic [4:0] act_q = 5'h00;
   assign supply_low_clear_o = act_q[0];
   assign reset_n_o = ~act_q[1];
   assign ext_int_o = act_q[2];
   assign wake_port_o = act_q[3];
   assign chip_enable_o = ~act_q[4];
   // Asserts source k for n cycles, then releases it.
   task pulse(input int k, input int n);
      @(posedge clk_i);
      act_q[k] <= 1'b1;
      repeat (n) @(posedge clk_i);
      act_q[k] <= 1'b0;
   endtask : pulse
endmodule : rsw_pins_model

//--- testbench.sv
// Self-checking bench for the reset sequencer.
// Assumes rsw_pins_model drives the pins and the checker is bound.
`include "rsw_regs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // =========================
   // Signals and instances
   logic clk_i = 0, rst_i = 1, ce_i = 1, instr_i = 0, wr_i = 0, rd_i = 0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00, rdata_o;
   logic slc, rstn, cen, eint, wake, osc, crst, run, thr;
   int n_errors = 0, cmp_count = 0, t;
   initial forever #5 clk_i = ~clk_i;
   rsw_pins_model pm_u (.clk_i, .supply_low_clear_o(slc), .reset_n_o(rstn),
      .chip_enable_o(cen), .ext_int_o(eint), .wake_port_o(wake));
   rsw_reset_seq #(.CARRY_HALF_CYC(20), .WD_LONG(16), .WD_SHORT(8)) dut_u (
      .clk_i, .rst_i, .ce_i, .supply_low_clear_i(slc), .reset_n_i(rstn),
      .chip_enable_i(cen), .ext_int_i(eint), .wake_port_i(wake), .instr_i,
      .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .osc_en_o(osc),
      .core_rst_o(crst), .core_run_o(run), .high_thresh_o(thr));
   task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         $display("FAIL %s exp %h got %h", nm, e, s);
         n_errors++;
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      chk("rdata", e, rdata_o & m);
   endtask : rd
   task wait_run(input logic v, input int lim);
      t = 0;
      while (run !== v && t < lim) begin
         @(negedge clk_i);
         t++;
      end
      chk("core_run", {7'h00, v}, {7'h00, run});
   endtask : wait_run
   task ins(input int n);
      repeat (n) begin
         @(posedge clk_i);
         instr_i <= 1'b1;
      end
      @(posedge clk_i);
      instr_i <= 1'b0;
   endtask : ins
   task results;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      results();
   end
   // =========================
   // Tests
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_run(1, 100);
      rd(`RSW_ADDR_WDSEL, 8'h03, `RSW_WDSEL_RST);
      wr(`RSW_ADDR_WDSEL, {6'h00, `RSW_WDSEL_64K});
      wr(`RSW_ADDR_WDSEL, {6'h00, `RSW_WDSEL_OFF});
      rd(`RSW_ADDR_WDSEL, 8'h03, 8'h01);
      $display("test wdsel done");
      repeat (4) begin
         ins(6);
         wr(`RSW_ADDR_KICK, 8'h01);
      end
      rd(`RSW_ADDR_STAT, 8'h01, 8'h00);
      ins(12);
      wait_run(0, 40);
      wait_run(1, 100);
      rd(`RSW_ADDR_STAT, 8'h01, 8'h01);
      rd(`RSW_ADDR_STAT, 8'h01, 8'h00);
      rd(`RSW_ADDR_WDSEL, 8'h03, 8'h01);
      $display("test watchdog done");
      for (int k = 0; k < 2; k++) begin
         pm_u.pulse(k, 6);
         @(negedge clk_i);
         chk("osc_en", 8'h00, {7'h00, osc});
         wait_run(1, 60);
         chk("delay", 8'h01, {7'h00, t >= 18});
         rd(`RSW_ADDR_WDSEL, 8'h03, 8'h03);
      end
      $display("test supply and pin done");
      ins(12);
      wr(`RSW_ADDR_KICK, 8'h01);
      ins(12);
      rd(`RSW_ADDR_STAT, 8'h01, 8'h00);
      pm_u.pulse(4, 3);
      wait_run(0, 60);
      wait_run(1, 60);
      $display("test chip enable done");
      for (int k = 2; k < 4; k++) begin
         wr(`RSW_ADDR_CTRL, 8'h01);
         repeat (4) @(negedge clk_i);
         chk("thresh", 8'h00, {7'h00, thr});
         pm_u.pulse(k, 2);
         wait_run(1, 100);
         chk("thresh", 8'h01, {7'h00, thr});
      end
      @(posedge clk_i);
      ce_i <= 1'b0;
      pm_u.pulse(0, 3);
      repeat (2) @(posedge clk_i);
      ce_i <= 1'b1;
      @(negedge clk_i);
      chk("core_run", 8'h01, {7'h00, run});
      chk("osc_en", 8'h01, {7'h00, osc});
      $display("test stop and enable done");
      results();
   end
endmodule : testbench
